// File: hdl/band_gain_estimator.sv
// Per-frame band gain estimator feeding the arithmetic coder
// Operation
// - Only listed flag combinations are accepted
// - Pick rescale factor and window length
// - Frames independent, except paired short frames
// - Target energy: root-mean power over band
// - Source energies through target-to-source line mapping
// - Band edges rescaled before any energy sum
// - Complex gain from log of energy ratio
// - Clamp every gain to 0 through 91
// - Real path energy: root-mean squared real part
// - Real path gain from log of energy
// - Gains handed on to the arithmetic coder
// - Band count and edges from mode table
// - Mapping starts at per-mode first source line
// - Every base edge rescaled by current factor
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module band_gain_estimator #(
   parameter int R_W = 16,
   parameter int P_W = 32,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic start,
   input wire band_gain_pkg::frame_flags_s flags,
   output logic busy,
   output logic done,
   output logic [band_gain_pkg::EDGE_W-1:0] target_line,
   output logic [band_gain_pkg::EDGE_W-1:0] source_line,
   input wire logic signed [R_W-1:0] real_target,
   input wire logic [P_W-1:0] power_target,
   input wire logic signed [R_W-1:0] real_source,
   input wire logic [P_W-1:0] power_source,
   output logic gain_valid,
   input wire logic gain_ready,
   output band_gain_pkg::gain_word_s gain_word
);
   localparam int EW = band_gain_pkg::EDGE_W;
   localparam int SW = band_gain_pkg::SUM_W;

   // Rescale an edge by the factor code
   function automatic logic [EW-1:0] rescale(input logic [EW-1:0] v, input logic [1:0] fac);
      logic [EW-1:0] r;
      r = v;
      if (fac == band_gain_pkg::FAC_5_4)
         r = v + (v >> 2);
      else if (fac == band_gain_pkg::FAC_HALF)
         r = v >> 1;
      return r;
   endfunction

   // Log2 in Q.10 by mantissa squaring; zero input gives zero
   function automatic int log2q(input logic [SW-1:0] v);
      int p;
      logic [SW-1:0] n;
      logic [15:0] m;
      logic [31:0] sq;
      int res;
      p = 0;
      for (int i = 0; i < SW; i++)
         if (v[i])
            p = i;
      n = v << (SW - 1 - p);
      m = n[SW-1 -: 16];
      res = p << band_gain_pkg::LOG_FRAC;
      for (int b = band_gain_pkg::LOG_FRAC - 1; b >= 0; b--)
      begin
         sq = m * m;
         if (sq[31])
         begin
            res = res + (1 << b);
            m = sq[31:16];
         end
         else
            m = sq[30:15];
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic [3:0] mode_reg;
   logic [31:0] next_rdata;
   logic [3:0] next_mode;
   logic err;
   logic paired;
   logic [3:0] mode_q;
   band_gain_pkg::frame_flags_s flags_q;
   logic [1:0] fac_q;

   // Mode steers the next frame; status shows the frame in hand
   always_comb
   begin
      next_mode = mode_reg;
      next_rdata = 32'h0;
      if (reg_write && reg_addr == band_gain_pkg::REG_CTRL)
         next_mode = reg_wdata[3:0];
      if (reg_read && reg_addr == band_gain_pkg::REG_CTRL)
         next_rdata = {28'h0, mode_reg};
      else if (reg_read && reg_addr == band_gain_pkg::REG_STATUS)
      begin
         next_rdata[band_gain_pkg::ST_BUSY] = busy;
         next_rdata[band_gain_pkg::ST_ERR] = err;
         next_rdata[band_gain_pkg::ST_PAIRED] = paired;
         next_rdata[band_gain_pkg::ST_INDEP] = flags_q.frame_independent_flag;
         next_rdata[band_gain_pkg::ST_FAC +: 2] = fac_q;
         next_rdata[band_gain_pkg::ST_WIN +: EW] = rescale(band_gain_pkg::BASE_WINDOW[mode_q], fac_q);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg <= band_gain_pkg::CTRL_RESET;
         reg_rdata <= 32'h0;
      end
      else
      begin
         mode_reg <= next_mode;
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edges and line mapping
   logic [EW-1:0] edge_line [band_gain_pkg::MAX_BANDS+1];
   logic [EW-1:0] src_of_tb;
   logic [EW-1:0] tb;
   logic [3:0] band;
   logic [3:0] nb;

   assign nb = band_gain_pkg::BAND_COUNT[mode_q];
   for (genvar k = 0; k <= band_gain_pkg::MAX_BANDS; k++)
   begin : g_edge
      assign edge_line[k] = rescale(band_gain_pkg::EDGE_TAB[mode_q][k], fac_q);
   end

   always_comb
   begin
      int off;
      int base;
      logic [3:0] st;
      off = 0;
      st = 4'h0;
      base = int'(edge_line[0]);
      for (int s = 0; s < 4; s++)
      begin
         st = band_gain_pkg::SEG_START[mode_q][s];
         if (st != band_gain_pkg::SEG_UNUSED && tb >= edge_line[st])
         begin
            base = int'(edge_line[st]);
            unique case (band_gain_pkg::SEG_OFF[mode_q][s])
               band_gain_pkg::OFF_32: off = int'(rescale(11'h020, fac_q));
               band_gain_pkg::OFF_46: off = int'(rescale(11'h02e, fac_q));
               band_gain_pkg::OFF_48: off = int'(rescale(11'h030, fac_q));
               band_gain_pkg::OFF_64: off = int'(rescale(11'h040, fac_q));
               band_gain_pkg::OFF_FIRST_LAST: off = 2 * int'(edge_line[0]) - int'(edge_line[nb]);
               band_gain_pkg::OFF_NINE_EIGHT: off = int'(edge_line[9]) - int'(edge_line[8]);
               default: off = 0;
            endcase
         end
      end
      src_of_tb = EW'(int'(band_gain_pkg::FIRST_SOURCE_LINE[mode_q]) + off + int'(tb) - base);
   end

   ////////////////////////////////////////////////////////////////////////
   // Gain of the finished band
   logic [SW-1:0] sum_t;
   logic [SW-1:0] sum_c;
   logic [SW-1:0] sum_r;
   logic [6:0] band_gain;

   // Sums of logs replace divisions and roots
   always_comb
   begin
      int d;
      int val;
      logic [SW-1:0] len;
      len = SW'(edge_line[band + 4'h1] - edge_line[band]);
      d = 0;
      val = 0;
      band_gain = 7'h0;
      if (flags_q.power_present)
      begin
         // Log terms of target power and real source, less power source and band length
         d = log2q(sum_t) + log2q(sum_r) - log2q(sum_c) - log2q(len);
         val = band_gain_pkg::GAIN_BIAS_Q + 2 * d;
         if (sum_c == '0)
            val = int'(band_gain_pkg::GAIN_MAX) << band_gain_pkg::LOG_FRAC;
         if (sum_t == '0 || sum_r == '0)
            val = 0;
      end
      else
      begin
         d = log2q(sum_r) - log2q(len);
         val = band_gain_pkg::GAIN_BIAS_Q + 2 * d;
         if (sum_r == '0)
            val = 0;
      end
      if (val < 0)
         band_gain = 7'h0;
      else if ((val >>> band_gain_pkg::LOG_FRAC) > int'(band_gain_pkg::GAIN_MAX))
         band_gain = band_gain_pkg::GAIN_MAX;
      else
         band_gain = 7'(val >>> band_gain_pkg::LOG_FRAC);
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ACC = 4'b0010,
      S_GAIN = 4'b0100,
      S_FLUSH = 4'b1000
   } state_e;
   state_e state;
   state_e next_state;
   logic [3:0] next_mode_q;
   band_gain_pkg::frame_flags_s next_flags_q;
   logic [1:0] next_fac_q;
   logic next_err;
   logic next_paired;
   logic [EW-1:0] next_tb;
   logic [3:0] next_band;
   logic [1:0] pend;
   logic [1:0] next_pend;
   logic [SW-1:0] next_sum_t;
   logic [SW-1:0] next_sum_c;
   logic [SW-1:0] next_sum_r;
   logic [EW-1:0] next_target_line;
   logic [EW-1:0] next_source_line;
   logic next_done;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_empty;
   logic short_ok;
   logic legal;

   assign busy = state != S_IDLE;
   // Short frames only at the four top rates, alone
   assign short_ok = mode_reg == band_gain_pkg::SWB_48K || mode_reg == band_gain_pkg::FB_48K ||
      mode_reg == band_gain_pkg::FB_96K || mode_reg == band_gain_pkg::FB_128K;
   assign legal = mode_reg < 4'(band_gain_pkg::MODES) && (flags.short_frame_flag ^ flags.long_frame_flag) &&
      !(flags.short_frame_flag && (flags.speech_to_transform_flag || !short_ok));
   assign buf_in_valid = state == S_GAIN;

   always_comb
   begin
      next_state = state;
      next_mode_q = mode_q;
      next_flags_q = flags_q;
      next_fac_q = fac_q;
      next_err = err;
      next_paired = paired;
      next_tb = tb;
      next_band = band;
      next_pend = {pend[0], 1'b0};
      next_sum_t = sum_t;
      next_sum_c = sum_c;
      next_sum_r = sum_r;
      next_target_line = target_line;
      next_source_line = source_line;
      next_done = 1'b0;
      // Accumulate samples read two cycles back
      if (pend[1])
      begin
         if (flags_q.power_present)
         begin
            next_sum_t = sum_t + SW'(power_target);
            next_sum_c = sum_c + SW'(power_source);
            // Widen before squaring; a self-sized product would wrap
            next_sum_r = sum_r + SW'(unsigned'((2*R_W)'(real_source) * (2*R_W)'(real_source)));
         end
         else
            next_sum_r = sum_r + SW'(unsigned'((2*R_W)'(real_target) * (2*R_W)'(real_target)));
      end
      unique case (state)
         S_IDLE:
         begin
            if (start)
            begin
               next_mode_q = mode_reg;
               next_flags_q = flags;
               next_err = !legal;
               // Second short frame in a row is marked
               next_paired = flags.short_frame_flag && flags_q.short_frame_flag && !err;
               // Factor from frame type and rate
               if (flags.short_frame_flag)
                  next_fac_q = band_gain_pkg::FAC_HALF;
               else if (flags.speech_to_transform_flag && mode_reg != band_gain_pkg::SWB_48K &&
                  mode_reg < band_gain_pkg::FB_48K)
                  next_fac_q = band_gain_pkg::FAC_5_4;
               else
                  next_fac_q = band_gain_pkg::FAC_UNITY;
               next_band = 4'h0;
               // All ones marks a fresh frame; no rescaled edge reaches it
               next_tb = {EW{1'b1}};
               next_sum_t = '0;
               next_sum_c = '0;
               next_sum_r = '0;
               next_state = legal ? S_ACC : S_FLUSH;
            end
         end
         S_ACC:
         begin
            if (tb == {EW{1'b1}})
               next_tb = edge_line[0];
            else if (tb < edge_line[band + 4'h1])
            begin
               next_target_line = tb;
               next_source_line = src_of_tb;
               next_pend[0] = 1'b1;
               next_tb = tb + 11'h1;
            end
            else if (pend == 2'h0)
               next_state = S_GAIN;
         end
         S_GAIN:
         begin
            // Gain enters the buffer to the coder
            if (buf_in_ready)
            begin
               next_band = band + 4'h1;
               next_sum_t = '0;
               next_sum_c = '0;
               next_sum_r = '0;
               next_state = (band + 4'h1 == nb) ? S_FLUSH : S_ACC;
            end
         end
         S_FLUSH:
         begin
            // Done once every gain has left
            if (buf_empty)
            begin
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         mode_q <= 4'h0;
         flags_q <= '0;
         fac_q <= band_gain_pkg::FAC_UNITY;
         err <= 1'b0;
         paired <= 1'b0;
         tb <= '0;
         band <= 4'h0;
         pend <= 2'h0;
         sum_t <= '0;
         sum_c <= '0;
         sum_r <= '0;
         target_line <= '0;
         source_line <= '0;
         done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         mode_q <= next_mode_q;
         flags_q <= next_flags_q;
         fac_q <= next_fac_q;
         err <= next_err;
         paired <= next_paired;
         tb <= next_tb;
         band <= next_band;
         pend <= next_pend;
         sum_t <= next_sum_t;
         sum_c <= next_sum_c;
         sum_r <= next_sum_r;
         target_line <= next_target_line;
         source_line <= next_source_line;
         done <= next_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output buffer; a full buffer holds the sequencer in S_GAIN
   band_gain_pkg::gain_word_s mem [DEPTH];
   logic [$clog2(DEPTH)-1:0] wr_ptr;
   logic [$clog2(DEPTH)-1:0] rd_ptr;
   logic [$clog2(DEPTH):0] count;
   logic [$clog2(DEPTH)-1:0] next_wr_ptr;
   logic [$clog2(DEPTH)-1:0] next_rd_ptr;
   logic [$clog2(DEPTH):0] next_count;
   logic push;
   logic pop;

   assign buf_in_ready = count != ($clog2(DEPTH)+1)'(DEPTH);
   assign buf_empty = count == '0;
   assign gain_valid = !buf_empty;
   assign gain_word = mem[rd_ptr];
   assign push = buf_in_valid && buf_in_ready;
   assign pop = gain_valid && gain_ready;

   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push)
         next_wr_ptr = (wr_ptr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
         next_rd_ptr = (rd_ptr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push)
         mem[wr_ptr] <= '{band: band, gain: band_gain, last: band + 4'h1 == nb};
   end
endmodule

// File: hdl/band_gain_pkg.sv
// Shared constants, tables and carriers of the band gain estimator
package band_gain_pkg;
   localparam int MODES = 13;
   localparam int MAX_BANDS = 10;
   localparam int EDGE_W = 11;
   localparam int SUM_W = 48;
   localparam int LOG_FRAC = 10;
   // Operating modes, bitrate and bandwidth
   typedef enum logic [3:0] {
      WB_9K6 = 4'h0, SWB_9K6 = 4'h1, SWB_13K2 = 4'h2, SWB_16K4 = 4'h3, SWB_24K4 = 4'h4,
      SWB_32K2 = 4'h5, SWB_48K = 4'h6, FB_16K4 = 4'h7, FB_24K4 = 4'h8, FB_32K = 4'h9,
      FB_48K = 4'ha, FB_96K = 4'hb, FB_128K = 4'hc
   } mode_e;
   // Edge rescale codes: unity, five quarters, one half
   localparam logic [1:0] FAC_UNITY = 2'h0;
   localparam logic [1:0] FAC_5_4 = 2'h1;
   localparam logic [1:0] FAC_HALF = 2'h2;
   // Source offset codes of the line mapping
   localparam logic [2:0] OFF_NONE = 3'h0;
   localparam logic [2:0] OFF_32 = 3'h1;
   localparam logic [2:0] OFF_46 = 3'h2;
   localparam logic [2:0] OFF_48 = 3'h3;
   localparam logic [2:0] OFF_64 = 3'h4;
   localparam logic [2:0] OFF_FIRST_LAST = 3'h5;
   localparam logic [2:0] OFF_NINE_EIGHT = 3'h6;
   localparam logic [3:0] SEG_UNUSED = 4'hf;
   localparam logic [3:0] BAND_COUNT [MODES] = '{4'h3, 4'h3, 4'h6, 4'h7, 4'h8, 4'h8, 4'h3, 4'h9, 4'ha,
      4'ha, 4'h4, 4'h2, 4'h2};
   localparam logic [6:0] FIRST_SOURCE_LINE [MODES] = '{7'h1e, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h40,
      7'h20, 7'h20, 7'h20, 7'h40, 7'h40, 7'h40};
   localparam logic [EDGE_W-1:0] BASE_WINDOW [MODES] = '{11'h140, 11'h280, 11'h280, 11'h280, 11'h280,
      11'h280, 11'h280, 11'h3c0, 11'h3c0, 11'h3c0, 11'h3c0, 11'h3c0, 11'h3c0};
   // Base band edges, decimal values 164..800, rows padded with zero
   localparam logic [EDGE_W-1:0] EDGE_TAB [MODES][MAX_BANDS+1] = '{
      '{11'h0a4, 11'h0ba, 11'h0f2, 11'h140, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h0c8, 11'h142, 11'h1bc, 11'h236, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1b0, 11'h1f0, 11'h236, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1b0, 11'h1f0, 11'h240, 11'h280, 11'h0, 11'h0, 11'h0},
      '{11'h100, 11'h11c, 11'h13e, 11'h166, 11'h192, 11'h1c2, 11'h1fc, 11'h240, 11'h280, 11'h0, 11'h0},
      '{11'h100, 11'h11c, 11'h13e, 11'h166, 11'h192, 11'h1c2, 11'h1fc, 11'h240, 11'h280, 11'h0, 11'h0},
      '{11'h200, 11'h216, 11'h240, 11'h280, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1b0, 11'h1f0, 11'h240, 11'h280, 11'h2d0, 11'h320, 11'h0},
      '{11'h100, 11'h11c, 11'h13e, 11'h166, 11'h192, 11'h1c2, 11'h1fc, 11'h240, 11'h280, 11'h2d0, 11'h320},
      '{11'h100, 11'h11c, 11'h13e, 11'h166, 11'h192, 11'h1c2, 11'h1fc, 11'h240, 11'h280, 11'h2d0, 11'h320},
      '{11'h200, 11'h248, 11'h290, 11'h2d8, 11'h320, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h280, 11'h2d0, 11'h320, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0},
      '{11'h280, 11'h2d0, 11'h320, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0}};
   // Line mapping segments: first band of each segment and its offset code
   localparam logic [3:0] SEG_START [MODES][4] = '{
      '{4'h0, 4'h2, 4'hf, 4'hf}, '{4'h0, 4'h1, 4'h2, 4'hf}, '{4'h0, 4'h4, 4'hf, 4'hf},
      '{4'h0, 4'h4, 4'h6, 4'hf}, '{4'h0, 4'h4, 4'h7, 4'hf}, '{4'h0, 4'h4, 4'h7, 4'hf},
      '{4'h0, 4'hf, 4'hf, 4'hf}, '{4'h0, 4'h4, 4'h7, 4'hf}, '{4'h0, 4'h4, 4'h6, 4'h9},
      '{4'h0, 4'h4, 4'h6, 4'h9}, '{4'h0, 4'hf, 4'hf, 4'hf}, '{4'h0, 4'hf, 4'hf, 4'hf},
      '{4'h0, 4'hf, 4'hf, 4'hf}};
   localparam logic [2:0] SEG_OFF [MODES][4] = '{
      '{3'h0, 3'h0, 3'h0, 3'h0}, '{3'h0, 3'h1, 3'h2, 3'h0}, '{3'h0, 3'h1, 3'h0, 3'h0},
      '{3'h0, 3'h3, 3'h4, 3'h0}, '{3'h0, 3'h1, 3'h4, 3'h0}, '{3'h0, 3'h1, 3'h4, 3'h0},
      '{3'h5, 3'h0, 3'h0, 3'h0}, '{3'h0, 3'h0, 3'h0, 3'h0}, '{3'h0, 3'h1, 3'h0, 3'h6},
      '{3'h0, 3'h1, 3'h0, 3'h6}, '{3'h5, 3'h0, 3'h0, 3'h0}, '{3'h5, 3'h0, 3'h0, 3'h0},
      '{3'h5, 3'h0, 3'h0, 3'h0}};
   // Gain arithmetic: bias is (16 + 1/2) in Q.10, ceiling 91
   localparam int GAIN_BIAS_Q = 16896;
   localparam logic [6:0] GAIN_MAX = 7'h5b;
   // Register map and fields
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam int ST_PAIRED = 2;
   localparam int ST_INDEP = 3;
   localparam int ST_FAC = 4;
   localparam int ST_WIN = 16;
   // Frame flags presented with each start
   typedef struct packed {
      logic transient_flag;
      logic short_frame_flag;
      logic long_frame_flag;
      logic speech_to_transform_flag;
      logic frame_independent_flag;
      logic power_present;
   } frame_flags_s;
   // One clamped band gain for the coder
   typedef struct packed {
      logic [3:0] band;
      logic [6:0] gain;
      logic last;
   } gain_word_s;
endpackage

// File: test/band_gain_estimator_tb.sv
// Self-checking bench of the band gain estimator
`timescale 1ns/1ps
module band_gain_estimator_tb;
   typedef struct packed {
      logic [3:0] mode;
      logic [5:0] fl;
      logic [15:0] r;
      logic [31:0] pt;
      logic [31:0] ps;
      logic [6:0] g;
      logic [10:0] win;
      logic [1:0] fac;
   } row_s;
   // Transition rows stand for a speech-coded previous frame
   localparam row_s ROWS [9] = '{
      '{4'h0, 6'h0a, 16'h1, 32'h0, 32'h0, 7'h10, 11'h140, 2'h0},
      '{4'h0, 6'h0c, 16'h0, 32'h0, 32'h0, 7'h00, 11'h190, 2'h1},
      '{4'h0, 6'h09, 16'h1, 32'h4, 32'h4, 7'h10, 11'h140, 2'h0},
      '{4'h0, 6'h09, 16'h1, 32'h4, 32'h0, 7'h5b, 11'h140, 2'h0},
      '{4'h0, 6'h09, 16'h4, 32'h100, 32'h1, 7'h28, 11'h140, 2'h0},
      '{4'h0, 6'h08, 16'h400, 32'h0, 32'h0, 7'h38, 11'h140, 2'h0},
      '{4'hb, 6'h10, 16'h1, 32'h0, 32'h0, 7'h10, 11'h1e0, 2'h2},
      '{4'h6, 6'h0c, 16'h1, 32'h0, 32'h0, 7'h10, 11'h280, 2'h0},
      '{4'h8, 6'h0c, 16'h1, 32'h0, 32'h0, 7'h10, 11'h4b0, 2'h1}};
   localparam logic [3:0] BAD_M [3] = '{4'h0, 4'hb, 4'h0};
   localparam logic [5:0] BAD_F [3] = '{6'h18, 6'h14, 6'h10};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic start = 1'b0;
   band_gain_pkg::frame_flags_s flags = '0;
   logic signed [15:0] r_val = 16'h0;
   logic [31:0] pt_val = 32'h0;
   logic [31:0] ps_val = 32'h0;
   logic stall = 1'b0;
   logic [31:0] reg_rdata, power_target, power_source, v;
   logic busy, done, gain_valid, gain_ready;
   logic [10:0] target_line, source_line;
   logic signed [15:0] real_target, real_source;
   band_gain_pkg::gain_word_s gain_word;
   logic [6:0] exp_g = 7'h0;
   int errors = 0;
   int tests_run = 0;
   int words = 0;
   int exp_n = 0;
   ////////////////////////////////////////////////////////////////////////////////
   band_gain_estimator dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .start, .flags,
      .busy, .done, .target_line, .source_line, .real_target, .power_target, .real_source, .power_source,
      .gain_valid, .gain_ready, .gain_word);
   spectrum_coder_model model (.clk, .r_val, .pt_val, .ps_val, .stall, .real_target, .power_target, .real_source,
      .power_source, .gain_ready);
   // Free-running 20 MHz clock
   always #25 clk = ~clk;
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // One frame: mode, start pulse, bounded wait for done, status read
   task automatic frame(input logic [3:0] m, input logic [5:0] f, input int n);
      int k = 0;
      reg_wr(band_gain_pkg::REG_CTRL, {28'h0, m});
      exp_n = n;
      words = 0;
      @(posedge clk);
      start <= 1'b1;
      flags <= f;
      @(posedge clk);
      start <= 1'b0;
      do
      begin
         @(posedge clk);
         #1 k++;
      end
      while (done !== 1'b1 && k < 5000);
      check("gain words", n, words);
      reg_rd(band_gain_pkg::REG_STATUS);
   endtask
   // Coder side: words in band order, last on the final band
   always @(posedge clk)
      if (gain_valid === 1'b1 && gain_ready === 1'b1)
      begin
         check("band", words, gain_word.band);
         check("gain", exp_g, gain_word.gain);
         check("last", words == exp_n - 1, gain_word.last);
         words++;
      end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check("rdata", 32'h0, reg_rdata);
      check("outputs", 3'h0, {busy, done, gain_valid});
      foreach (ROWS[i])
      begin
         r_val <= ROWS[i].r;
         pt_val <= ROWS[i].pt;
         ps_val <= ROWS[i].ps;
         exp_g = ROWS[i].g;
         stall <= i[0];
         frame(ROWS[i].mode, ROWS[i].fl, band_gain_pkg::BAND_COUNT[ROWS[i].mode]);
         check("status", {5'h0, ROWS[i].win, 10'h0, ROWS[i].fac, ROWS[i].fl[1], 3'h0}, v);
      end
      // Two short frames back to back, second one paired
      for (int j = 0; j < 2; j++)
      begin
         frame(band_gain_pkg::FB_96K, 6'h10, 2);
         check("paired", j, v[2]);
      end
      // Last line of the short frame, first-last mapping at half rescale
      check("target line", 11'h18f, target_line);
      check("source line", 11'h17f, source_line);
      // Refused flag mixes and a short frame at a low rate give no gains
      foreach (BAD_F[j])
      begin
         frame(BAD_M[j], BAD_F[j], 0);
         check("error bit", 1'b1, v[1]);
      end
      reg_wr(4'h7, 32'hffffffff);
      reg_rd(4'h7);
      check("unmapped", 32'h0, v);
      end_of_test();
   end
   // Watchdog, far beyond the few thousand cycles needed
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      end_of_test();
   end
endmodule

// File: test/band_gain_props.sv
// Port checker of the band gain estimator
`timescale 1ns/1ps
module band_gain_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire band_gain_pkg::frame_flags_s flags,
   input wire logic busy,
   input wire logic done,
   input wire logic gain_valid,
   input wire logic gain_ready,
   input wire band_gain_pkg::gain_word_s gain_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Frame handshake
   done_pulse_a: assert property (done |=> !done)
      else $error("done longer than one cycle");
   busy_start_a: assert property (start && !busy |=> busy)
      else $error("start did not make busy");
   idle_quiet_a: assert property (!busy |-> !gain_valid)
      else $error("gain word outside a frame");
   // Refused flag mixes end two cycles after start
   mixed_flags_a: assert property (start && !busy && flags.short_frame_flag && flags.long_frame_flag |-> ##2 done)
      else $error("mixed frame kinds not refused");
   short_trans_a: assert property (start && !busy && flags.short_frame_flag && flags.speech_to_transform_flag
      |-> ##2 done)
      else $error("short frame with transition not refused");
   // Gain words to the coder
   gain_range_a: assert property (gain_valid |-> gain_word.gain <= band_gain_pkg::GAIN_MAX)
      else $error("gain above ceiling");
   word_hold_a: assert property (gain_valid && !gain_ready |=> gain_valid && $stable(gain_word))
      else $error("stalled word lost or changed");
   last_done_a: assert property (gain_valid && gain_ready && gain_word.last |-> ##[1:8] done)
      else $error("no done after final word");
   cover property (gain_valid && !gain_ready);
   cover property (gain_valid && gain_word.gain == band_gain_pkg::GAIN_MAX);
   cover property (start && !busy && flags.short_frame_flag);
endmodule
bind band_gain_estimator band_gain_props props (.clk(clk), .rst(rst), .start(start), .flags(flags), .busy(busy),
   .done(done), .gain_valid(gain_valid), .gain_ready(gain_ready), .gain_word(gain_word));

// File: test/spectrum_coder_model.sv
// Flat spectrum supplier and stalling gain coder
`timescale 1ns/1ps
module spectrum_coder_model (
   input wire logic clk,
   input wire logic signed [15:0] r_val,
   input wire logic [31:0] pt_val,
   input wire logic [31:0] ps_val,
   input wire logic stall,
   output logic signed [15:0] real_target,
   output logic [31:0] power_target,
   output logic signed [15:0] real_source,
   output logic [31:0] power_source,
   output logic gain_ready
);
   logic [1:0] tick = 2'h0;
   // Flat spectrum held through the frame
   always_ff @(posedge clk)
   begin
      real_target <= r_val;
      power_target <= pt_val;
      real_source <= r_val;
      power_source <= ps_val;
      tick <= tick + 2'h1;
   end
   // Stalls two cycles in four, too briefly to fill the buffer
   assign gain_ready = !stall || tick[1];
endmodule
